// *** logic/rsr_map.vh ***
`ifndef RSR_MAP_VH
`define RSR_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RSR_ADR_FSM_STATE 16'hdf3b
`define RSR_ADR_PKT_FLAGS 16'hdf3c
`define RSR_ADR_PLL_CAL 16'hdf3d
`define RSR_ADR_IRQ_STATUS 16'hdf40
`define RSR_ADR_IRQ_MASK 16'hdf44
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSR_RST_STATE 5'h01
`define RSR_RST_PLL_CAL 8'h94
`define RSR_RST_IRQ 4'h0
// ----------------------------------------
// State codes
// ----------------------------------------
`define RSR_ST_SLEEP 5'h00
`define RSR_ST_IDLE 5'h01
`define RSR_ST_UNUSED 5'h02
`define RSR_ST_RX 5'h0d
`define RSR_ST_RX_RST 5'h0f
`define RSR_ST_RX_OVERFLOW 5'h11
`define RSR_ST_TX_UNDERFLOW 5'h16
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSR_BIT_CRC 7
`define RSR_BIT_CS 6
`define RSR_BIT_PQT 5
`define RSR_BIT_CCA 4
`define RSR_BIT_FRAME 3
`define RSR_FSM_MSB 4
// Live flag slots
`define RSR_LIVE_W 3
`define RSR_LIVE_CCA 0
`define RSR_LIVE_PQT 1
`define RSR_LIVE_CS 2
// Interrupt bits
`define RSR_IRQ_CRC 0
`define RSR_IRQ_FRAME_ON 1
`define RSR_IRQ_FRAME_OFF 2
`define RSR_IRQ_STATE 3
`define RSR_IRQ_W 4
`endif

// *** logic/rsr_top.v ***
// Behaviour
// - The state register shows a 5-bit control state code in bits 4:0 and resets to the idle code.
// - Receive and transmit states use their fixed codes and code 00010 is never shown.
// - Bit 7 of packet flags is set on a CRC match and cleared when receive is entered or restarted.
// - Bit 3 rises when the sync word is sent or received and falls at packet end.
// - In receive bit 3 falls early on an address filter reject or on receive overflow.
// - In transmit bit 3 falls early on transmit underflow.
// - The PLL calibration current reads as an 8-bit test value that resets to 0x94.
// - The digital regulator is switched off in either of the two deepest power modes.
// - Registers hold their values while the regulator is off and resume with them on wakeup.
`include "rsr_map.vh"
`default_nettype none
module rsr_top (
    // Clock and reset
    input wire MCLK_I,
    input wire RST_N_I,
    // Wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [15:0] WB_ADR_I,
    input wire [7:0] WB_DAT_I,
    output wire [7:0] WB_DAT_O,
    output wire WB_ACK_O,
    // Radio core status, same clock
    input wire [4:0] FSM_STATE_I,
    input wire CRC_DONE_I,
    input wire CRC_MATCH_I,
    input wire SYNC_SEEN_I,
    input wire PACKET_END_I,
    input wire ADDR_REJECT_I,
    input wire CARRIER_SENSE_I,
    input wire PREAMBLE_QUALITY_I,
    input wire CLEAR_CHANNEL_I,
    input wire PLL_CAL_VALID_I,
    input wire [7:0] PLL_CAL_I,
    // Power control
    input wire DEEP_POWER_MODE_A_I,
    input wire DEEP_POWER_MODE_B_I,
    output wire REG_ENABLE_O,
    // Interrupt
    output wire IRQ_O
);

// ----------------------------------------
// Decode helpers
// ----------------------------------------
// Register select for one bus address
function adr_hit;
    input [15:0] adr;
    input [15:0] target;
    begin
        adr_hit = (adr == target);
    end
endfunction

// Entry into receive or its restart
function is_rx_entry;
    input [4:0] code;
    begin
        is_rx_entry = (code == `RSR_ST_RX) | (code == `RSR_ST_RX_RST);
    end
endfunction

// Gap code is never shown
function is_latchable;
    input [4:0] code;
    begin
        is_latchable = (code != `RSR_ST_UNUSED);
    end
endfunction

// States that cut a frame short
function is_frame_abort;
    input [4:0] code;
    begin
        is_frame_abort = (code == `RSR_ST_RX_OVERFLOW)
            | (code == `RSR_ST_TX_UNDERFLOW);
    end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [4:0] state_ff;
reg crc_ff;
reg frame_ff;
reg [7:0] pll_ff;
reg ack_ff;
reg [7:0] dat_ff;
reg [`RSR_IRQ_W-1:0] irq_st_ff;
reg [`RSR_IRQ_W-1:0] irq_mask_ff;

// ----------------------------------------
// Bus request decode
// ----------------------------------------
wire bus_req;
wire bus_rd;
wire bus_wr;
wire rd_status;
wire wr_mask;
// One request per cycle, none while ack stands
assign bus_req = WB_CYC_I & WB_STB_I & ~ack_ff;
assign bus_rd = bus_req & ~WB_WE_I;
assign bus_wr = bus_req & WB_WE_I;
assign rd_status = bus_rd & adr_hit(WB_ADR_I, `RSR_ADR_IRQ_STATUS);
assign wr_mask = bus_wr & adr_hit(WB_ADR_I, `RSR_ADR_IRQ_MASK);

// ----------------------------------------
// Control state capture
// ----------------------------------------
wire state_chg;
wire [4:0] nxt_state;
assign state_chg = (FSM_STATE_I != state_ff) & is_latchable(FSM_STATE_I);
assign nxt_state = state_chg ? FSM_STATE_I : state_ff;

always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        state_ff <= `RSR_RST_STATE;
    end else begin
        state_ff <= nxt_state;
    end
end

// ----------------------------------------
// CRC match flag
// ----------------------------------------
wire rx_enter;
wire nxt_crc;
// Entry or restart clears, and beats a CRC result in the same cycle
assign rx_enter = state_chg & is_rx_entry(FSM_STATE_I);
assign nxt_crc = rx_enter ? 1'h0 : (CRC_DONE_I ? CRC_MATCH_I : crc_ff);

always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        crc_ff <= 1'h0;
    end else begin
        crc_ff <= nxt_crc;
    end
end

// ----------------------------------------
// Frame active flag
// ----------------------------------------
wire frame_drop;
wire nxt_frame;
// Any drop beats a sync in the same cycle
assign frame_drop = PACKET_END_I
    | ADDR_REJECT_I
    | is_frame_abort(FSM_STATE_I);
assign nxt_frame = frame_drop ? 1'h0 : (SYNC_SEEN_I ? 1'h1 : frame_ff);

always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        frame_ff <= 1'h0;
    end else begin
        frame_ff <= nxt_frame;
    end
end

// ----------------------------------------
// Live demodulator flags
// ----------------------------------------
wire [`RSR_LIVE_W-1:0] live_in;
wire [`RSR_LIVE_W-1:0] live_q;
assign live_in[`RSR_LIVE_CCA] = CLEAR_CHANNEL_I;
assign live_in[`RSR_LIVE_PQT] = PREAMBLE_QUALITY_I;
assign live_in[`RSR_LIVE_CS] = CARRIER_SENSE_I;

genvar gi;
generate
    for (gi = 0; gi < `RSR_LIVE_W; gi = gi + 1) begin : g_live
        reg bit_ff;
        always @(posedge MCLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                bit_ff <= 1'h0;
            end else begin
                bit_ff <= live_in[gi];
            end
        end
        assign live_q[gi] = bit_ff;
    end
endgenerate

// ----------------------------------------
// PLL calibration value
// ----------------------------------------
always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        pll_ff <= `RSR_RST_PLL_CAL;
    end else if (PLL_CAL_VALID_I) begin
        pll_ff <= PLL_CAL_I;
    end
end

// ----------------------------------------
// Digital regulator
// ----------------------------------------
wire deep_mode;
assign deep_mode = DEEP_POWER_MODE_A_I | DEEP_POWER_MODE_B_I;
// No flop resets on deep_mode, so contents survive regulator off
assign REG_ENABLE_O = ~deep_mode;

// ----------------------------------------
// Interrupt status, set wins over read clear
// ----------------------------------------
wire [`RSR_IRQ_W-1:0] irq_ev;
wire [`RSR_IRQ_W-1:0] irq_kept;
wire [`RSR_IRQ_W-1:0] nxt_irq_st;
assign irq_ev[`RSR_IRQ_CRC] = CRC_DONE_I & CRC_MATCH_I & ~rx_enter;
assign irq_ev[`RSR_IRQ_FRAME_ON] = ~frame_ff & nxt_frame;
assign irq_ev[`RSR_IRQ_FRAME_OFF] = frame_ff & ~nxt_frame;
assign irq_ev[`RSR_IRQ_STATE] = state_chg;
assign irq_kept = rd_status ? {`RSR_IRQ_W{1'h0}} : irq_st_ff;
assign nxt_irq_st = irq_kept | irq_ev;
assign IRQ_O = |(irq_st_ff & irq_mask_ff);

always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        irq_st_ff <= `RSR_RST_IRQ;
    end else begin
        irq_st_ff <= nxt_irq_st;
    end
end

// Only the mask takes writes
always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        irq_mask_ff <= `RSR_RST_IRQ;
    end else if (wr_mask) begin
        irq_mask_ff <= WB_DAT_I[`RSR_IRQ_W-1:0];
    end
end

// ----------------------------------------
// Read words
// ----------------------------------------
reg [7:0] state_word;
reg [7:0] flag_word;
reg [7:0] status_word;
reg [7:0] mask_word;
reg [7:0] rd_mux;

always @* begin
    state_word = 8'h00;
    state_word[`RSR_FSM_MSB:0] = state_ff;
end

always @* begin
    flag_word = 8'h00;
    flag_word[`RSR_BIT_CRC] = crc_ff;
    flag_word[`RSR_BIT_CS] = live_q[`RSR_LIVE_CS];
    flag_word[`RSR_BIT_PQT] = live_q[`RSR_LIVE_PQT];
    flag_word[`RSR_BIT_CCA] = live_q[`RSR_LIVE_CCA];
    flag_word[`RSR_BIT_FRAME] = frame_ff;
end

always @* begin
    status_word = 8'h00;
    status_word[`RSR_IRQ_W-1:0] = irq_st_ff;
end

always @* begin
    mask_word = 8'h00;
    mask_word[`RSR_IRQ_W-1:0] = irq_mask_ff;
end

always @* begin
    rd_mux = 8'h00;
    case (WB_ADR_I)
        `RSR_ADR_FSM_STATE: rd_mux = state_word;
        `RSR_ADR_PKT_FLAGS: rd_mux = flag_word;
        `RSR_ADR_PLL_CAL: rd_mux = pll_ff;
        `RSR_ADR_IRQ_STATUS: rd_mux = status_word;
        `RSR_ADR_IRQ_MASK: rd_mux = mask_word;
        default: rd_mux = 8'h00;
    endcase
end

// ----------------------------------------
// Wishbone answer, ack one cycle after request
// ----------------------------------------
always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        ack_ff <= 1'h0;
    end else begin
        ack_ff <= bus_req;
    end
end

// Read data stands until the next read
always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        dat_ff <= 8'h00;
    end else if (bus_rd) begin
        dat_ff <= rd_mux;
    end
end

assign WB_ACK_O = ack_ff;
assign WB_DAT_O = dat_ff;

endmodule // rsr_top
`default_nettype wire

// *** verification/radio_status_readout_bench.sv ***
`default_nettype none
module radio_status_readout_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic c = 0, rn = 0, cyc = 0, stb = 0, we = 0, mt = 0, ro, irq, ack;
    logic [15:0] adr = 0;
    logic [7:0] dw = 0, dat, rd, pc = 0;
    logic [4:0] st = 1, p = 0, e = 1;
    logic [2:0] lf = 0;
    logic [1:0] pm = 0;
    int errors = 0, checked = 0, seed = 9, n, k;
    always #2.5 c = ~c;
    rsr_top u_rsr_top (.MCLK_I(c), .RST_N_I(rn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_DAT_I(dw), .WB_DAT_O(dat), .WB_ACK_O(ack), .FSM_STATE_I(st), .CRC_DONE_I(p[3]), .CRC_MATCH_I(mt),
        .SYNC_SEEN_I(p[2]), .PACKET_END_I(p[1]), .ADDR_REJECT_I(p[0]), .CARRIER_SENSE_I(lf[2]),
        .PREAMBLE_QUALITY_I(lf[1]), .CLEAR_CHANNEL_I(lf[0]), .PLL_CAL_VALID_I(p[4]), .PLL_CAL_I(pc),
        .DEEP_POWER_MODE_A_I(pm[0]), .DEEP_POWER_MODE_B_I(pm[1]), .REG_ENABLE_O(ro), .IRQ_O(irq));
    function automatic logic [7:0] pk(input logic r, input logic [2:0] l, input logic f);
        return {r, l, f, 3'h0};
    endfunction
    task close_out;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, x);
        end
    endtask
    task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
        n = 0;
        do begin @(posedge c); n++; end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin errors++; close_out; end
        rd = dat;
        {cyc, stb, we} <= 3'b000;
        @(posedge c);
    endtask
    task rdc(input logic [15:0] a, input logic [7:0] x); bus(0, a, 8'h00); chk(rd, x); endtask
    task pu(input logic [4:0] v); p <= v; @(posedge c); p <= 5'h00; repeat (3) @(posedge c); endtask
    task ir(input logic [7:0] x); @(negedge c); chk({6'h0, irq, ro}, x); @(posedge c); endtask
    task fr(input logic [4:0] s, input logic [4:0] q, input logic [4:0] t);
        st <= 5'h01;
        @(posedge c);
        st <= s;
        pu(5'h04);
        rdc(16'hdf3c, pk(0, lf, 1));
        st <= t;
        pu(q);
        rdc(16'hdf3c, pk(0, lf, 0));
    endtask
    initial begin
        repeat (16) @(posedge c);
        rn <= 1;
        rdc(16'hdf3b, 8'h01);
        rdc(16'hdf3d, 8'h94);
        bus(1, 16'hdf3b, 8'hff);
        rdc(16'hdf3b, 8'h01);
        rdc(16'hdf00, 8'h00);
        for (int i = 0; i < 12; i++) begin
            k = $unsigned($random(seed)) % 23;
            st <= (i == 0) ? 5'h02 : 5'(k);
            lf <= 3'($random(seed));
            if (i > 0 && k != 2) e = 5'(k);
            repeat (3) @(posedge c);
            rdc(16'hdf3b, {3'h0, e});
            rdc(16'hdf3c, pk(0, lf, 0));
        end
        $display("state test done");
        ir(8'h01);
        bus(1, 16'hdf44, 8'h01);
        mt <= 1;
        pu(5'h08);
        ir(8'h03);
        rdc(16'hdf3c, pk(1, lf, 0));
        bus(0, 16'hdf40, 8'h00);
        chk({7'h0, rd[0]}, 8'h01);
        ir(8'h01);
        fr(5'h0d, 5'h02, 5'h0d);
        fr(5'h0d, 5'h01, 5'h0d);
        fr(5'h0d, 5'h00, 5'h11);
        fr(5'h13, 5'h00, 5'h16);
        rdc(16'hdf40, 8'h0e);
        rdc(16'hdf40, 8'h00);
        pc <= 8'($random(seed));
        pu(5'h10);
        rdc(16'hdf3d, pc);
        pm <= 2'b10;
        ir(8'h00);
        rdc(16'hdf3b, 8'h16);
        $display("flag test done");
        rn <= 0;
        repeat (2) @(posedge c);
        rn <= 1;
        rdc(16'hdf3d, 8'h94);
        rdc(16'hdf44, 8'h00);
        $display("reset test done");
        close_out;
    end
endmodule // radio_status_readout_bench
bind rsr_top rsr_sva u_rsr_sva (.MCLK_I, .RST_N_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ACK_O, .REG_ENABLE_O,
    .CARRIER_SENSE_I, .DEEP_POWER_MODE_A_I, .DEEP_POWER_MODE_B_I, .WB_ADR_I, .WB_DAT_O, .FSM_STATE_I);
`default_nettype wire

// *** verification/rsr_top_sva.sv ***
`default_nettype none
module rsr_sva (
    input wire logic MCLK_I, RST_N_I, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, REG_ENABLE_O, CARRIER_SENSE_I,
    input wire logic DEEP_POWER_MODE_A_I, DEEP_POWER_MODE_B_I,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [7:0] WB_DAT_O,
    input wire logic [4:0] FSM_STATE_I
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence tk; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
    sequence rq(a); tk ##0 !WB_WE_I && WB_ADR_I == a; endsequence
    ack_answer_a: assert property (tk |=> WB_ACK_O) else $error("no ack");
    state_pad_a: assert property (rq(16'hdf3b) |=> WB_DAT_O[7:5] == 3'h0) else $error("pad");
    state_gap_a: assert property (rq(16'hdf3b) |=> WB_DAT_O[4:0] != 5'h02) else $error("gap");
    flag_pad_a: assert property (rq(16'hdf3c) |=> WB_DAT_O[2:0] == 3'h0) else $error("pad");
    carrier_live_a: assert property (CARRIER_SENSE_I [*3] ##0 rq(16'hdf3c) |=> WB_DAT_O[6]) else $error("cs");
    overflow_drop_a: assert property ((FSM_STATE_I == 5'h11) [*3] ##0 rq(16'hdf3c) |=> !WB_DAT_O[3]) else $error("ovf");
    underflow_drop_a: assert property ((FSM_STATE_I == 5'h16) [*3] ##0 rq(16'hdf3c) |=> !WB_DAT_O[3]) else $error("unf");
    reg_off_a: assert property (REG_ENABLE_O == !(DEEP_POWER_MODE_A_I || DEEP_POWER_MODE_B_I)) else $error("reg");
endmodule // rsr_sva
`default_nettype wire
